// [pkg/swl_pkg.sv]
// constants, register map and state codes for the data-strobe link block
package swl_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_TIME     = 8'h08;
    localparam logic [7:0] OFS_CLKDIV   = 8'h0C;
    // control register fields
    localparam int CTRL_DIS_BIT   = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_AUTO_BIT  = 2;
    localparam int CTRL_TICK_BIT  = 4;
    localparam int CTRL_TIME_TX_BIT = 10;
    localparam int CTRL_TIME_RX_BIT = 11;
    // status register fields
    localparam int STAT_NULL_BIT  = 4;
    localparam int STAT_TICKO_BIT = 8;
    // clock divisor fields and reset values
    localparam int DIV_LINK_LSB   = 8;
    localparam logic [7:0] DIV_LINK_RST = 8'h01;
    localparam logic [7:0] DIV_RUN_RST  = 8'h00;
    // control character codes, sent least significant bit first
    localparam logic [7:0] CODE_FCT = 8'h00;
    localparam logic [7:0] CODE_EOP = 8'h01;
    localparam logic [7:0] CODE_EEP = 8'h02;
    localparam logic [7:0] CODE_ESC = 8'h03;
    localparam logic [5:0] CRED_MAX  = 6'h38;
    localparam logic [5:0] CRED_FCT  = 6'h30;
    localparam logic [5:0] CRED_STEP = 6'h08;
    // timing, in ns and then in pclk cycles
    localparam int CLK_NS   = 50;
    localparam int ERST_NS  = 6400;
    localparam int EWAIT_NS = 12800;
    localparam int DISC_NS  = 850;
    localparam logic [8:0] ERST_CYC  = 9'((ERST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] EWAIT_CYC = 9'((EWAIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] DISC_CYC  = 9'(DISC_NS / CLK_NS);
    // second half of a two-character sequence
    localparam logic [1:0] SEC_NONE = 2'h0;
    localparam logic [1:0] SEC_FCT  = 2'h1;
    localparam logic [1:0] SEC_TIME = 2'h2;
    typedef enum logic [2:0] {
        ST_ERESET  = 3'h0,
        ST_EWAIT   = 3'h1,
        ST_READY   = 3'h2,
        ST_STARTED = 3'h3,
        ST_CONN    = 3'h4,
        ST_RUN     = 3'h5
    } swl_state_e;
endpackage

// [hw/swl_link.sv]
// data-strobe link interface: exchange fsm, credits, tx/rx characters, time codes
// Operation
// R1: link disable blocks start or forces error reset
// R2: start needs link start, or autostart plus null
// R3: state readable; state limits transmittable characters
// R4: time code sent only in run on request
// R5: flow control tokens only in connecting/run
// R6: credit cap 56; token if <=48, room+8
// R7: data sent only in run with credit, data
// R8: nulls fill when nothing else may go
// R9: credits up per token, down per data
// R10: length-driven packets, end marker, then done notify
// R11: receiver active after error reset, needs null
// R12: parity, escape, credit errors force error reset
// R13: disconnect timed on the system clock
// R14: link chars consumed; repeat end markers dropped
// R15: all crossings synchronised to system clock
// R16: time code is control bits plus count
// R17: count resets zero; tick increments and sends
// R18: tick ignored while pending; cleared when sent
// R19: received tick flag sticky, write one clears
// R20: count follows received codes, software writable
// R21: control bits kept when count is current+1
// R22: bit rate from link or run divisor+1
`timescale 1ns/10ps
module swl_link
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // link pins
    input  wire logic                rx_d,
    input  wire logic                rx_s,
    output logic                     tx_d,
    output logic                     tx_s,
    // transmit packet source
    input  wire logic                pkt_len_valid,
    input  wire logic [15:0]         pkt_len,
    input  wire logic                pkt_eep,
    output logic                     pkt_len_ready,
    output logic                     pkt_done,
    input  wire logic                tx_valid,
    input  wire logic [7:0]          tx_data,
    output logic                     tx_ready,
    // receive fifo sink
    output logic                     rx_valid,
    output logic [8:0]               rx_data,
    input  wire logic [6:0]          rx_free
);
    import swl_pkg::*;

    function automatic logic [9:0] swl_char(input logic ctl, input logic [7:0] v,
                                            input logic pp);
        swl_char = {v, ctl, 1'b1 ^ ctl ^ pp}; // odd parity over previous data + flag
    endfunction

    swl_state_e  state_r, state_nxt;
    logic [8:0]  tmr_r;
    logic        link_dis_r, link_start_r, autostart_r;
    logic        time_transmit_enable_r, time_receive_enable_r;
    logic [7:0]  div_link_r, div_run_r, div_cnt_r;
    logic [5:0]  time_cnt_r, in_cnt_r, out_cnt_r;
    logic [1:0]  time_ctl_r, tx_sec_r;
    logic        tick_pend_r, tick_out_r;
    logic [31:0] prdata_r;
    logic [13:0] tx_sh_r;
    logic [3:0]  tx_cnt_r, rx_n_r;
    logic        tx_par_r, tx_d_r, tx_s_r;
    logic        pkt_act_r, pkt_done_r;
    logic [15:0] pkt_rem_r;
    logic        rd1_r, rd2_r, rd3_r, rs1_r, rs2_r, rs3_r;
    logic [9:0]  rx_sh_r;
    logic        rx_flag_r, rx_par_r, rx_esc_r, rx_null_r, rx_seen_r, last_eop_r;
    logic [8:0]  disc_r;
    logic        rx_valid_r;
    logic [8:0]  rx_data_r;

    // apb decode; zero wait states, read data captured in the setup cycle
    wire        acc      = psel & penable;
    wire        hit      = paddr == OFS_CTRL || paddr == OFS_STATUS ||
                           paddr == OFS_TIME || paddr == OFS_CLKDIV;
    wire        wr       = acc & pwrite & hit;
    wire        wr_ctrl  = wr & (paddr == OFS_CTRL);
    wire        wr_stat  = wr & (paddr == OFS_STATUS);
    wire        wr_time  = wr & (paddr == OFS_TIME);
    wire        wr_div   = wr & (paddr == OFS_CLKDIV);
    wire        tick_req = wr_ctrl & pwdata[CTRL_TICK_BIT] & time_transmit_enable_r &
                           ~tick_pend_r; // R17 R18
    wire [31:0] rd_mux   =
        (paddr == OFS_CTRL)   ? {20'h0_0000, time_receive_enable_r, time_transmit_enable_r,
                                 5'h00, tick_pend_r, 1'b0, autostart_r, link_start_r, link_dis_r} :
        (paddr == OFS_STATUS) ? {23'h00_0000, tick_out_r, 3'h0, rx_null_r, 1'b0,
                                 state_r} : // R3
        (paddr == OFS_TIME)   ? {24'h00_0000, time_ctl_r, time_cnt_r} :
        (paddr == OFS_CLKDIV) ? {16'h0000, div_link_r, div_run_r} : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_r;

    // receiver: pins pass two flops, third flop only remembers the old level
    wire       rx_en   = state_r != ST_ERESET; // R11
    wire       rx_bit  = rx_en & ((rd2_r ^ rd3_r) | (rs2_r ^ rs3_r)); // R13 R15
    wire [9:0] rx_sh_n = {rd2_r, rx_sh_r[9:1]};
    wire [3:0] rx_n_n  = rx_n_r + 4'h1;
    wire       c_done  = rx_bit & (rx_n_n == 4'h4) & rx_flag_r;
    wire       d_done  = rx_bit & (rx_n_n == 4'hA);
    wire [1:0] c_code  = rx_sh_n[9:8];
    wire       c_par   = rx_sh_n[6] ^ 1'b1 ^ rx_par_r;
    wire       d_par   = rx_sh_n[0] ^ rx_par_r;
    wire       par_err = rx_null_r & ((c_done & ~c_par) | (d_done & ~d_par)); // R12
    wire       esc_err = rx_null_r & rx_esc_r & c_done & (c_code != CODE_FCT[1:0]); // R12
    wire       null_ev = rx_esc_r & c_done & (c_code == CODE_FCT[1:0]);
    wire       fct_ev  = rx_null_r & ~rx_esc_r & c_done & (c_code == CODE_FCT[1:0]);
    wire       eop_ev  = rx_null_r & ~rx_esc_r & c_done & (c_code[1] ^ c_code[0]);
    wire       dat_ev  = rx_null_r & ~rx_esc_r & d_done;
    wire       time_ev = rx_null_r & rx_esc_r & d_done;
    wire       disc_err = rx_seen_r & (disc_r >= DISC_CYC); // R13
    wire       cred_err = (fct_ev & (in_cnt_r > CRED_FCT)) |
                          ((dat_ev | eop_ev) & (out_cnt_r == 6'h00)); // R12
    wire       seq_err  = ((dat_ev | eop_ev | time_ev) & state_r != ST_RUN) |
                          (fct_ev & state_r != ST_CONN & state_r != ST_RUN);
    wire       rx_err   = par_err | esc_err | disc_err | cred_err | seq_err;
    wire       push_dat = dat_ev & state_r == ST_RUN;
    wire       push_eop = eop_ev & state_r == ST_RUN & ~last_eop_r; // R14

    // exchange level state machine
    wire stop_req = rx_err | link_dis_r; // R1 R12
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_ERESET:  if (tmr_r >= ERST_CYC) state_nxt = ST_EWAIT;
            ST_EWAIT:   if (rx_err) state_nxt = ST_ERESET;
                        else if (tmr_r >= EWAIT_CYC) state_nxt = ST_READY;
            ST_READY:   if (rx_err) state_nxt = ST_ERESET;
                        else if (~link_dis_r & (link_start_r | (autostart_r & rx_null_r)))
                            state_nxt = ST_STARTED; // R1 R2
            ST_STARTED: if (stop_req | tmr_r >= EWAIT_CYC) state_nxt = ST_ERESET;
                        else if (rx_null_r) state_nxt = ST_CONN;
            ST_CONN:    if (stop_req | tmr_r >= EWAIT_CYC) state_nxt = ST_ERESET;
                        else if (fct_ev) state_nxt = ST_RUN;
            ST_RUN:     if (stop_req) state_nxt = ST_ERESET;
            default:    state_nxt = ST_ERESET;
        endcase
    end

    // transmitter character selection, one decision per character boundary
    wire       run     = state_r == ST_RUN;
    wire       tx_on   = state_r == ST_STARTED | state_r == ST_CONN | run; // R8
    wire [7:0] div_sel = run ? div_run_r : div_link_r; // R22
    wire       bit_tk  = div_cnt_r == div_sel;
    wire       tx_load = tx_on & bit_tk & (tx_cnt_r == 4'h0);
    wire       sel_sec = tx_sec_r != SEC_NONE;
    wire       sel_tim = ~sel_sec & run & time_transmit_enable_r & tick_pend_r; // R4 R16
    wire       fct_ok  = (state_r == ST_CONN | run) & (out_cnt_r <= CRED_FCT) &
                         ({1'b0, rx_free} >= {2'b00, out_cnt_r} + 8'h08); // R5 R6
    wire       sel_fct = ~sel_sec & ~sel_tim & fct_ok;
    wire       nch_ok  = run & (in_cnt_r != 6'h00) & pkt_act_r &
                         ((pkt_rem_r == 16'h0000) | tx_valid); // R7
    wire       sel_nch = ~sel_sec & ~sel_tim & ~sel_fct & nch_ok;
    wire       sel_dat = sel_nch & (pkt_rem_r != 16'h0000);
    wire       sel_eop = sel_nch & (pkt_rem_r == 16'h0000); // R10
    wire       sel_nul = ~sel_sec & ~sel_tim & ~sel_fct & ~sel_nch; // R8
    wire       is_dat  = (tx_sec_r == SEC_TIME) | sel_dat;
    wire [7:0] tx_v    = (tx_sec_r == SEC_FCT)  ? CODE_FCT :
                         (tx_sec_r == SEC_TIME) ? {time_ctl_r, time_cnt_r} : // R16
                         sel_fct ? CODE_FCT : sel_dat ? tx_data :
                         sel_eop ? (pkt_eep ? CODE_EEP : CODE_EOP) : CODE_ESC;
    wire [9:0] tx_w    = swl_char(~is_dat, tx_v, tx_par_r);
    wire       tx_b    = tx_load ? tx_w[0] : tx_sh_r[0];
    wire       tx_step = tx_load | (tx_on & bit_tk & tx_cnt_r != 4'h0);
    wire       tim_out = tx_load & (tx_sec_r == SEC_TIME);

    assign tx_ready      = tx_load & sel_dat; // R7 R10
    assign pkt_len_ready = ~pkt_act_r;
    assign pkt_done      = pkt_done_r;
    assign tx_d          = tx_d_r;
    assign tx_s          = tx_s_r;
    assign rx_valid      = rx_valid_r;
    assign rx_data       = rx_data_r;

    // registers and time interface
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {link_dis_r, link_start_r, autostart_r} <= 3'h0;
            {time_transmit_enable_r, time_receive_enable_r} <= 2'h0;
            div_link_r  <= DIV_LINK_RST;
            div_run_r   <= DIV_RUN_RST;
            time_cnt_r  <= 6'h00; // R17
            time_ctl_r  <= 2'h0;
            tick_pend_r <= 1'b0;
            tick_out_r  <= 1'b0;
            prdata_r    <= 32'h0000_0000;
        end
        else
        begin
            if (psel & ~penable & ~pwrite) prdata_r <= rd_mux;
            if (wr_ctrl)
            begin
                link_dis_r   <= pwdata[CTRL_DIS_BIT];
                link_start_r <= pwdata[CTRL_START_BIT];
                autostart_r  <= pwdata[CTRL_AUTO_BIT];
                time_transmit_enable_r <= pwdata[CTRL_TIME_TX_BIT];
                time_receive_enable_r  <= pwdata[CTRL_TIME_RX_BIT];
            end
            if (wr_div) {div_link_r, div_run_r} <= pwdata[15:0];
            // a received code wins over a software write in the same cycle
            if (time_ev & time_receive_enable_r)
            begin
                if (rx_sh_n[7:2] == time_cnt_r + 6'h01) time_ctl_r <= rx_sh_n[9:8]; // R21
                time_cnt_r <= rx_sh_n[7:2]; // R20
            end
            else if (tick_req) time_cnt_r <= time_cnt_r + 6'h01; // R17
            else if (wr_time) {time_ctl_r, time_cnt_r} <= pwdata[7:0]; // R20
            if (tick_req) tick_pend_r <= 1'b1; // R17
            else if (tim_out | ~time_transmit_enable_r) tick_pend_r <= 1'b0; // R18
            if (time_ev & time_receive_enable_r) tick_out_r <= 1'b1; // R19
            else if (wr_stat & pwdata[STAT_TICKO_BIT]) tick_out_r <= 1'b0;
        end
    end

    // fsm, timers, credit counters and bit divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= ST_ERESET;
            tmr_r     <= 9'h000;
            div_cnt_r <= 8'h00;
            in_cnt_r  <= 6'h00;
            out_cnt_r <= 6'h00;
        end
        else
        begin
            state_r   <= state_nxt;
            tmr_r     <= (state_nxt != state_r) ? 9'h000 : tmr_r + 9'h001;
            div_cnt_r <= (bit_tk | ~tx_on) ? 8'h00 : div_cnt_r + 8'h01; // R22
            if (state_r == ST_ERESET)
            begin
                in_cnt_r  <= 6'h00;
                out_cnt_r <= 6'h00;
            end
            else
            begin
                in_cnt_r  <= in_cnt_r + ((fct_ev & ~cred_err) ? CRED_STEP : 6'h00)
                             - {5'h00, tx_load & sel_nch}; // R9
                out_cnt_r <= out_cnt_r + ((tx_load & sel_fct) ? CRED_STEP : 6'h00)
                             - {5'h00, push_dat | (eop_ev & run & ~cred_err)}; // R6
            end
        end
    end

    // transmit shifter and packet counter; strobe toggles when data repeats
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_sh_r    <= 14'h0000;
            tx_cnt_r   <= 4'h0;
            tx_sec_r   <= SEC_NONE;
            tx_par_r   <= 1'b0;
            tx_d_r     <= 1'b0;
            tx_s_r     <= 1'b0;
            pkt_act_r  <= 1'b0;
            pkt_rem_r  <= 16'h0000;
            pkt_done_r <= 1'b0;
        end
        else
        begin
            pkt_done_r <= tx_load & sel_eop; // R10
            if (~pkt_act_r & pkt_len_valid)
            begin
                pkt_act_r <= 1'b1;
                pkt_rem_r <= pkt_len;
            end
            else if (tx_load & sel_dat) pkt_rem_r <= pkt_rem_r - 16'h0001;
            else if (tx_load & sel_eop) pkt_act_r <= 1'b0;
            if (~tx_on)
            begin
                {tx_d_r, tx_s_r, tx_par_r} <= 3'h0;
                tx_cnt_r <= 4'h0;
                tx_sec_r <= SEC_NONE;
            end
            else if (tx_step)
            begin
                tx_d_r   <= tx_b;
                tx_s_r   <= tx_s_r ^ (tx_b == tx_d_r);
                tx_sh_r  <= tx_load ? {5'h00, tx_w[9:1]} : {1'b0, tx_sh_r[13:1]};
                tx_cnt_r <= tx_load ? (is_dat ? 4'h9 : 4'h3) : tx_cnt_r - 4'h1;
                if (tx_load)
                begin
                    tx_par_r <= ^tx_v;
                    tx_sec_r <= sel_tim ? SEC_TIME : sel_nul ? SEC_FCT : SEC_NONE; // R8
                end
            end
        end
    end

    // receive decoder, disconnect timer and fifo push
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {rd1_r, rd2_r, rd3_r, rs1_r, rs2_r, rs3_r} <= 6'h00;
            rx_sh_r    <= 10'h000;
            rx_n_r     <= 4'h0;
            {rx_flag_r, rx_par_r, rx_esc_r, rx_null_r, rx_seen_r} <= 5'h00;
            last_eop_r <= 1'b0;
            disc_r     <= 9'h000;
            rx_valid_r <= 1'b0;
            rx_data_r  <= 9'h000;
        end
        else
        begin
            {rd1_r, rd2_r, rd3_r} <= {rx_d, rd1_r, rd2_r}; // R15
            {rs1_r, rs2_r, rs3_r} <= {rx_s, rs1_r, rs2_r};
            rx_valid_r <= push_dat | push_eop; // R14
            if (push_dat | push_eop)
                rx_data_r <= push_dat ? {1'b0, rx_sh_n[9:2]} : {1'b1, 7'h00, c_code[1]};
            if (push_dat) last_eop_r <= 1'b0;
            else if (push_eop) last_eop_r <= 1'b1;
            if (~rx_en)
            begin
                rx_n_r <= 4'h0;
                {rx_flag_r, rx_par_r, rx_esc_r, rx_null_r, rx_seen_r} <= 5'h00; // R11
                disc_r <= 9'h000;
            end
            else
            begin
                disc_r <= rx_bit ? 9'h000 : (disc_err ? disc_r : disc_r + 9'h001);
                if (rx_bit)
                begin
                    rx_seen_r <= 1'b1;
                    rx_sh_r   <= rx_sh_n;
                    rx_n_r    <= (c_done | d_done) ? 4'h0 : rx_n_n;
                    if (rx_n_n == 4'h2) rx_flag_r <= rd2_r;
                end
                if (c_done)
                begin
                    rx_par_r <= ^c_code;
                    rx_esc_r <= c_code == CODE_ESC[1:0];
                end
                else if (d_done)
                begin
                    rx_par_r <= ^rx_sh_n[9:2];
                    rx_esc_r <= 1'b0;
                end
                if (null_ev) rx_null_r <= 1'b1; // R11
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_tick_taken;
        tick_req ##1 tick_pend_r;
    endsequence

    a_dis_no_start: assert property (link_dis_r && state_r == ST_READY |=> state_r != ST_STARTED)
        else $error("started while link disabled"); // R1
    a_dis_forces_reset: assert property (link_dis_r && state_r >= ST_STARTED |=> state_r == ST_ERESET)
        else $error("disable did not force error reset"); // R1
    a_start_cause: assert property (state_r == ST_READY && state_nxt == ST_STARTED
            |-> link_start_r || (autostart_r && rx_null_r))
        else $error("start without cause"); // R2
    a_nchar_in_run: assert property (tx_ready |-> run && in_cnt_r != 6'h00 && tx_valid)
        else $error("data sent outside run or without credit"); // R7
    a_fct_allowed: assert property (tx_load && sel_fct |-> out_cnt_r <= CRED_FCT
            && (state_r == ST_CONN || run))
        else $error("token sent when not allowed"); // R5
    a_credit_cap: assert property (in_cnt_r <= CRED_MAX && out_cnt_r <= CRED_MAX)
        else $error("credit counter above cap"); // R6
    a_credit_down: assert property (tx_ready && !fct_ev && !rx_err && run
            |=> in_cnt_r == $past(in_cnt_r) - 6'h01)
        else $error("credit not consumed by data"); // R9
    a_err_reset: assert property (rx_err && state_r != ST_ERESET |=> state_r == ST_ERESET)
        else $error("receive error did not reset link"); // R12
    a_tick_count: assert property (s_tick_taken |-> time_cnt_r == $past(time_cnt_r, 1) + 6'h01
            || $past(time_ev))
        else $error("tick did not advance count"); // R17
    a_tickout_hold: assert property (tick_out_r && !(wr_stat && pwdata[STAT_TICKO_BIT])
            |=> tick_out_r)
        else $error("received tick flag lost"); // R19
endmodule

// [verification/swl_peer.sv]
// behavioural remote node: drives data-strobe characters into the link receiver
`timescale 1ns/10ps
module swl_peer
(
    // clock
    input  wire logic pclk,
    // link pins toward the block
    output logic      rx_d,
    output logic      rx_s,
    // link pins from the block
    input  wire logic tx_d,
    input  wire logic tx_s
);
    logic [8:0] q[$];      // bit8 set marks a control char, low bits the code or data
    logic       on   = 1'b0;
    logic       bad  = 1'b0;
    logic       prv  = 1'b0;
    logic       pt   = 1'b0;   // last d xor s seen on the block's transmit pins
    logic       fl   = 1'b0;
    logic [1:0] cd   = 2'h0;
    int         nb   = 0;
    int         eops = 0;
    int         eeps = 0;

    // decoder of the block's transmitter; frames from the first bit after reset,
    // so it is only valid while the transmitter has not been switched off
    always @(posedge pclk)
    begin
        if ((tx_d ^ tx_s) != pt)
        begin
            pt = tx_d ^ tx_s;
            nb++;
            if (nb == 2) fl = tx_d;
            if (nb == 3) cd[0] = tx_d;
            if (nb == 4 && fl)
            begin
                cd[1] = tx_d;
                eops += (cd == 2'h1);
                eeps += (cd == 2'h2);
                nb = 0;
            end
            else if (nb == 10) nb = 0;
        end
    end

    // one bit held 4 pclk, since the receiver needs at least 3 per bit
    task automatic bitout(input logic b);
        @(posedge pclk);
        rx_s <= rx_s ^ (b == rx_d);
        rx_d <= b;
        repeat (3) @(posedge pclk);
    endtask

    // odd parity covers the previous char's data bits, this parity and flag
    task automatic chr(input logic [8:0] c);
        int n;
        n = c[8] ? 2 : 8;
        bitout(~(prv ^ c[8]) ^ bad);
        bad = 1'b0;
        bitout(c[8]);
        for (int i = 0; i < n; i++) bitout(c[i]);
        prv = c[8] ? ^c[1:0] : ^c[7:0];
    endtask

    // lines stand still until enabled, then nulls fill every gap
    initial
    begin
        rx_d = 1'b0;
        rx_s = 1'b0;
        forever
        begin
            if (!on) @(posedge pclk);
            else if (q.size() > 0) chr(q.pop_front());
            else
            begin
                chr(9'h103);
                chr(9'h100);
            end
        end
    end
endmodule

// [verification/swl_link_test.sv]
// self-checking bench for the data-strobe link block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module swl_link_test;
    import swl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rx_d, rx_s, tx_d, tx_s, pkt_len_ready, pkt_done;
    logic pkt_len_valid = 0, pkt_eep = 0, tx_valid = 0, tx_ready, rx_valid;
    logic [15:0] pkt_len = 16'h0;
    logic [7:0] tx_data = 8'h00;
    logic [8:0] rx_data, rxq[$];
    logic [6:0] rx_free = 7'h40;
    logic prev_t = 0;
    int miscompares = 0, total_checks = 0, tog = 0, rdy = 0, dn = 0;

    always #25 pclk = ~pclk;
    swl_peer i_peer (.pclk(pclk), .rx_d(rx_d), .rx_s(rx_s), .tx_d(tx_d), .tx_s(tx_s));
    swl_link i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_d(rx_d), .rx_s(rx_s), .tx_d(tx_d), .tx_s(tx_s),
        .pkt_len_valid(pkt_len_valid), .pkt_len(pkt_len), .pkt_eep(pkt_eep),
        .pkt_len_ready(pkt_len_ready), .pkt_done(pkt_done), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_free(rx_free));

    // monitors on the falling edge, clear of the tasks that reset the counters
    // d xor s flips once per bit, so flips count bit periods
    always @(negedge pclk)
    begin
        if ((tx_d ^ tx_s) != prev_t) tog++;
        prev_t <= tx_d ^ tx_s;
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (tx_ready === 1'b1) rdy++;
        if (pkt_done === 1'b1) dn++;
    end

    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic wait_st(input logic [2:0] s, input int lim);
        do begin apb(0, OFS_STATUS, 0); lim--; end while (rd[2:0] !== s && lim > 0);
        `CHK("link state", s, rd[2:0])
    endtask

    task automatic t_reset;
        apb(0, OFS_STATUS, 0);
        `CHK("state after reset", 3'h0, rd[2:0])
        apb(0, OFS_TIME, 0);
        `CHK("time after reset", 32'h0, rd)
        apb(0, OFS_CLKDIV, 0);
        `CHK("divisor reset", {16'h0, DIV_LINK_RST, DIV_RUN_RST}, rd)
        apb(0, 8'h10, 0);
        `CHK("unmapped error", 1'b1, err)
        apb(1, OFS_CLKDIV, 32'h0101);
        $display("reset test done");
    endtask

    // disable wins over start; no start without start bit or autostart
    task automatic t_start;
        apb(1, OFS_CTRL, 32'h3);
        repeat (700) @(posedge pclk);
        wait_st(ST_READY, 1);
        tog = 0;
        repeat (40) @(posedge pclk);
        `CHK("idle transmitter", 0, tog)
        apb(1, OFS_CTRL, 32'h0);
        i_peer.on = 1;
        repeat (200) @(posedge pclk);
        wait_st(ST_READY, 1);
        apb(1, OFS_CTRL, 32'h4);
        wait_st(ST_CONN, 100);
        i_peer.q.push_back(9'h100);
        wait_st(ST_RUN, 100);
        `CHK("null seen", 1'b1, rd[STAT_NULL_BIT])
        tog = 0;
        repeat (40) @(posedge pclk);
        `CHK("run bit rate", 20, tog)
        $display("start test done");
    endtask

    task automatic t_data;
        i_peer.q.push_back(9'h0A5);
        i_peer.q.push_back(9'h101);
        i_peer.q.push_back(9'h101);
        repeat (300) @(posedge pclk);
        `CHK("rx count", 2, rxq.size())
        `CHK("rx data", 9'h0A5, rxq[0])
        `CHK("rx marker", 9'h100, rxq[1])
        rdy = 0;
        dn = 0;
        pkt_len <= 16'h2; pkt_len_valid <= 1; tx_valid <= 1; tx_data <= 8'h3C;
        @(posedge pclk);
        pkt_len_valid <= 0;
        for (int i = 0; i < 2000 && dn == 0; i++) @(posedge pclk);
        // zero-length packet ended by an error marker
        tx_valid <= 0;
        pkt_len <= 16'h0;
        pkt_eep <= 1;
        pkt_len_valid <= 1;
        @(posedge pclk);
        pkt_len_valid <= 0;
        for (int i = 0; i < 2000 && dn < 2; i++) @(posedge pclk);
        repeat (40) @(posedge pclk);
        pkt_eep <= 0;
        `CHK("bytes pulled", 2, rdy)
        `CHK("packets done", 2, dn)
        `CHK("eop sent", 1, i_peer.eops)
        `CHK("eep sent", 1, i_peer.eeps)
        $display("data test done");
    endtask

    task automatic t_time;
        // enable first, so the second request lands while the first is pending
        apb(1, OFS_CTRL, 32'h404);
        apb(1, OFS_CTRL, 32'h414);
        apb(1, OFS_CTRL, 32'h414);
        for (int i = 0; i < 200 && rd[CTRL_TICK_BIT] !== 1'b0; i++) apb(0, OFS_CTRL, 0);
        `CHK("tick cleared", 1'b0, rd[CTRL_TICK_BIT])
        apb(0, OFS_TIME, 0);
        `CHK("count once", 8'h01, rd[7:0])
        apb(1, OFS_CTRL, 32'h804);
        i_peer.q.push_back(9'h103);
        i_peer.q.push_back(9'h082);
        repeat (200) @(posedge pclk);
        apb(0, OFS_TIME, 0);
        `CHK("time received", 8'h82, rd[7:0])
        apb(0, OFS_STATUS, 0);
        `CHK("tick out set", 1'b1, rd[STAT_TICKO_BIT])
        apb(1, OFS_STATUS, 32'h100);
        apb(0, OFS_STATUS, 0);
        `CHK("tick out clear", 1'b0, rd[STAT_TICKO_BIT])
        $display("time test done");
    endtask

    // a parity fault from the far end must drop the link
    task automatic t_err;
        i_peer.bad = 1;
        wait_st(ST_ERESET, 60);
        $display("error test done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_start;
        t_data;
        t_time;
        t_err;
        stop_test;
    end

    // watchdog sized well beyond the expected run
    initial
    begin
        #3000000;
        miscompares++;
        stop_test;
    end
endmodule
